// ===== pkg/idq_pkg.sv
// Package: port offsets, index codes, field positions, timing counts
// Assumes a 100 MHz local bus clock
package idq_pkg;
    // Port offsets from the board base
    localparam logic [1:0] PORT_INDEX = 2'h0;
    localparam logic [1:0] PORT_CTRL = 2'h1;
    localparam logic [1:0] PORT_LSB = 2'h2;
    localparam logic [1:0] PORT_MSB = 2'h3;
    // Index codes
    localparam logic [7:0] IDX_ADC = 8'h00;
    localparam logic [7:0] IDX_MUX = 8'h01;
    localparam logic [7:0] IDX_ANALOG_OUT_A = 8'h02;
    localparam logic [7:0] IDX_ANALOG_OUT_B = 8'h03;
    localparam logic [7:0] IDX_CT0 = 8'h04;
    localparam logic [7:0] IDX_CT1 = 8'h05;
    localparam logic [7:0] IDX_CT2 = 8'h06;
    localparam logic [7:0] IDX_CTCTL = 8'h07;
    localparam logic [7:0] IDX_CTCLR = 8'h08;
    localparam logic [7:0] IDX_DIOCFG = 8'h09;
    localparam logic [7:0] IDX_DIOLO = 8'h0a;
    localparam logic [7:0] IDX_DIOHI = 8'h0b;
    localparam logic [7:0] IDX_USER_IND = 8'h80;
    localparam logic [7:0] IDX_BOARD_IDENTIFICATION = 8'h81;
    // Field positions
    localparam int STAT_ADC_RDY = 0;
    localparam int STAT_CT_RDY = 1;
    localparam int USER_IND_BIT = 0;
    localparam int MUX_W = 4;
    localparam int ADC_W = 12;
    localparam int DIO_W = 16;
    // Reset values
    localparam logic [7:0] INDEX_RST = 8'h00;
    localparam logic [3:0] DIOCFG_RST = 4'h0;
    localparam logic [11:0] DAC_RST = 12'h000;
    // Arbitrary neutral board identification value
    localparam logic [7:0] BOARD_IDENTIFICATION_VAL = 8'h5a;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRIG_MIN_NS = 250;
    localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
endpackage

// ===== pkg/idq_bus_if.sv
// Interface: decoded register strobes from the bus front end
// Assumes one clock domain
`timescale 1ns/100ps
interface idq_bus_if;
    logic wr;
    logic rd;
    logic [1:0] port;
    logic [7:0] index;
    logic [7:0] wdata;
    modport front (output wr, output rd, output port, output index,
        output wdata);
    modport core (input wr, input rd, input port, input index,
        input wdata);
endinterface

// ===== verilog/idq_bus_front.sv
// Bus front end: holds the index register, passes decoded strobes
// Assumes byte-wide read/write strobes synchronous to ref_clk_i
`timescale 1ns/100ps
module idq_bus_front
    import idq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Local bus
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    // Decoded strobes
    idq_bus_if.front bus
);
    logic [7:0] index_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            index_r <= INDEX_RST;
        end else if (wr_i && addr_i == PORT_INDEX) begin
            index_r <= wdata_i; // RQ1
        end
    end

    assign bus.wr = wr_i;
    assign bus.rd = rd_i;
    assign bus.port = addr_i;
    assign bus.index = index_r;
    assign bus.wdata = wdata_i;
endmodule // idq_bus_front

// ===== verilog/idq_trig_filter.sv
// Trigger qualifier: one start per low pulse of at least MIN_CYC cycles on a trigger input
// Assumes input synchronous to ref_clk_i
`timescale 1ns/100ps
module idq_trig_filter
    import idq_pkg::*;
#(
    parameter int MIN_CYC = TRIG_MIN_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Trigger
    input wire logic enable_i,
    input wire logic level_n_i,
    output logic start_o
);
    logic [7:0] low_cnt_r;
    logic fired_r;

    // Count low time; fire once after the minimum width
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_r <= 8'h00;
            fired_r <= 1'b0;
        end else if (level_n_i || !enable_i) begin
            low_cnt_r <= 8'h00;
            fired_r <= 1'b0;
        end else begin
            if (low_cnt_r != 8'hff) begin
                low_cnt_r <= low_cnt_r + 8'h01;
            end
            if (low_cnt_r == 8'(MIN_CYC - 1)) begin
                fired_r <= 1'b1;
            end
        end
    end

    assign start_o = enable_i && !level_n_i && !fired_r
        && low_cnt_r == 8'(MIN_CYC - 1); // RQ14
endmodule // idq_trig_filter

// ===== verilog/idq_daq_ctrl.sv
// Indexed control logic for a data-acquisition card
// Assumes a bridge local bus with byte strobes, one clock, board straps
// Operation
// RQ1: Index written at base port selects register for the next port.
// RQ2: Index 80 bit 0 turns the user indicator off or on.
// RQ3: Index 81 read returns a fixed board identification byte.
// RQ4: One interrupt output shared by ADC done and counter 1 output.
// RQ5: Counter interrupt stays pending until a write with index 8.
// RQ6: Status bit 1 reads 0 after counter 1 rises; clear sets it.
// RQ7: ADC interrupt clears on high-byte result access.
// RQ8: Hold 12-bit result; mux channel from index 1 low bits.
// RQ9: Three strap-enabled conversion start sources.
// RQ10: Write to index 0 at control port starts one conversion.
// RQ11: Software waits about 50 us after changing the mux.
// RQ12: Status bit 0 reads 0 after conversion until high-byte read.
// RQ13: Result low nibble at third port, high byte at fourth.
// RQ14: Low hardware and timer triggers start a conversion.
// RQ15: Software reads old result within 6 us of a new trigger.
// RQ16: DAC load via index 2 or 3, low then high port.
// RQ17: DAC low nibble taken from written bits 4-7.
// RQ18: Sixteen I/O lines in four nibbles with own direction.
// RQ19: Index 9 bits 0-3: 0 output, 1 input per nibble.
// RQ20: Index 0A and 0B read present line levels.
// RQ21: At reset each nibble drives its strap level.
// RQ22: Three 16-bit counters; channel 0 triggers, channel 1 interrupts.
// RQ23: Counter 0 is used in mode 2 by software.
// RQ24: Strap selects counter 0 clock: channel 2 output or 1 MHz.
// RQ25: Channel 2 rising edges 250 ns to 6 us apart.
// RQ26: Four port decode; unused indices read zero, ignore writes.
`timescale 1ns/100ps
module idq_daq_ctrl
    import idq_pkg::*;
#(
    parameter int MIN_TRIG_CYC = TRIG_MIN_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Bridge local bus
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Interrupt
    output logic irq_o,
    // Straps
    input wire logic [2:0] adc_trigger_straps_i,
    input wire logic [3:0] dio_reset_straps_i,
    input wire logic counter0_clock_strap_i,
    // ADC converter
    output logic adc_start_o,
    input wire logic adc_done_i,
    input wire logic [11:0] adc_data_i,
    output logic [3:0] mux_sel_o,
    input wire logic ext_convert_n_i,
    // DAC
    output logic [11:0] analog_out_a_o,
    output logic [11:0] analog_out_b_o,
    // Digital I/O
    input wire logic [15:0] dio_i,
    output logic [15:0] dio_o,
    output logic [15:0] dio_oe_o,
    // Counter/timer core
    output logic ct_wr_o,
    output logic ct_rd_o,
    output logic [1:0] ct_sel_o,
    output logic [7:0] ct_wdata_o,
    input wire logic [7:0] ct_rdata_i,
    output logic ct0_clk_sel_o,
    input wire logic counter0_output_i,
    input wire logic counter1_output_i,
    // Indicator
    output logic user_ind_o
);
    idq_bus_if bus ();

    logic [11:0] adc_r;
    logic adc_pend_r;
    logic ct_pend_r;
    logic ct1_d_r;
    logic [3:0] mux_r;
    logic [3:0] dac_lo_a_r;
    logic [3:0] dac_lo_b_r;
    logic [11:0] dac_a_r;
    logic [11:0] dac_b_r;
    logic [3:0] diocfg_r;
    logic [15:0] dio_out_r;
    logic strap_load_r;
    logic user_ind_r;
    logic [7:0] rdata_r;
    logic adc_start_r;
    logic hw_start;
    logic tmr_start;
    logic sw_start;

    idq_bus_front u_front (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .bus(bus)
    );

    function automatic logic acc(input logic [1:0] p, input logic [7:0] i);
        acc = bus.port == p && bus.index == i;
    endfunction

    // Strap bit per nibble, widened to its four lines
    function automatic logic [15:0] strap_lvl(input logic [3:0] s);
        strap_lvl = 16'h0000;
        for (int n = 0; n < 4; n++) begin
            strap_lvl[n*4 +: 4] = {4{s[n]}};
        end
    endfunction

    // Start sources
    assign sw_start = adc_trigger_straps_i[0] && bus.wr
        && acc(PORT_CTRL, IDX_ADC); // RQ10

    idq_trig_filter #(.MIN_CYC(MIN_TRIG_CYC)) u_hw_trig (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .enable_i(adc_trigger_straps_i[1]),
        .level_n_i(ext_convert_n_i),
        .start_o(hw_start)
    );

    idq_trig_filter #(.MIN_CYC(MIN_TRIG_CYC)) u_tmr_trig (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .enable_i(adc_trigger_straps_i[2]),
        .level_n_i(counter0_output_i), // RQ22
        .start_o(tmr_start)
    );

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_start_r <= 1'b0;
        end else begin
            adc_start_r <= sw_start || hw_start || tmr_start; // RQ9
        end
    end

    // Result capture and ADC pending flag; completion wins over clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_r <= 12'h000;
            adc_pend_r <= 1'b0;
        end else if (adc_done_i) begin
            adc_r <= adc_data_i; // RQ8
            adc_pend_r <= 1'b1; // RQ12
        end else if ((bus.rd || bus.wr) && acc(PORT_MSB, IDX_ADC)) begin
            adc_pend_r <= 1'b0; // RQ7
        end
    end

    // Counter 1 rising edge latches pending; set wins over clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ct1_d_r <= 1'b0;
            ct_pend_r <= 1'b0;
        end else begin
            ct1_d_r <= counter1_output_i;
            if (counter1_output_i && !ct1_d_r) begin
                ct_pend_r <= 1'b1; // RQ6
            end else if (bus.wr && acc(PORT_CTRL, IDX_CTCLR)) begin
                ct_pend_r <= 1'b0; // RQ5
            end
        end
    end

    assign irq_o = adc_pend_r || ct_pend_r; // RQ4

    // Mux select
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mux_r <= 4'h0;
        end else if (bus.wr && acc(PORT_CTRL, IDX_MUX)) begin
            mux_r <= bus.wdata[MUX_W-1:0]; // RQ8
        end
    end

    // DAC registers: low nibble held, loaded with the high byte
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dac_lo_a_r <= 4'h0;
            dac_lo_b_r <= 4'h0;
            dac_a_r <= DAC_RST;
            dac_b_r <= DAC_RST;
        end else if (bus.wr) begin
            if (acc(PORT_LSB, IDX_ANALOG_OUT_A)) begin
                dac_lo_a_r <= bus.wdata[7:4]; // RQ17
            end
            if (acc(PORT_LSB, IDX_ANALOG_OUT_B)) begin
                dac_lo_b_r <= bus.wdata[7:4]; // RQ17
            end
            if (acc(PORT_MSB, IDX_ANALOG_OUT_A)) begin
                dac_a_r <= {bus.wdata, dac_lo_a_r}; // RQ16
            end
            if (acc(PORT_MSB, IDX_ANALOG_OUT_B)) begin
                dac_b_r <= {bus.wdata, dac_lo_b_r}; // RQ16
            end
        end
    end

    // Digital I/O direction and output latch
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            diocfg_r <= DIOCFG_RST;
        end else if (bus.wr && acc(PORT_CTRL, IDX_DIOCFG)) begin
            diocfg_r <= bus.wdata[3:0]; // RQ19
        end
    end

    // Strap levels are captured on the first edge after reset release
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_load_r <= 1'b1;
            dio_out_r <= 16'h0000;
        end else if (strap_load_r) begin
            strap_load_r <= 1'b0;
            dio_out_r <= strap_lvl(dio_reset_straps_i); // RQ21
        end else if (bus.wr && acc(PORT_CTRL, IDX_DIOLO)) begin
            dio_out_r[7:0] <= bus.wdata;
        end else if (bus.wr && acc(PORT_CTRL, IDX_DIOHI)) begin
            dio_out_r[15:8] <= bus.wdata;
        end
    end

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            dio_oe_o[n*4 +: 4] = {4{!diocfg_r[n]}}; // RQ18
        end
    end

    // Straps drive the lines through reset until the first edge
    assign dio_o = strap_load_r ? strap_lvl(dio_reset_straps_i)
        : dio_out_r; // RQ21

    // User indicator
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            user_ind_r <= 1'b0;
        end else if (bus.wr && acc(PORT_CTRL, IDX_USER_IND)) begin
            user_ind_r <= bus.wdata[USER_IND_BIT]; // RQ2
        end
    end

    // Read data register, valid the cycle after the read strobe
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            rdata_r <= 8'h00; // RQ26
            if (bus.port == PORT_CTRL) begin
                unique case (bus.index)
                    IDX_ADC: begin
                        rdata_r <= {6'h00, !ct_pend_r, !adc_pend_r}; // RQ12
                    end
                    IDX_CT0, IDX_CT1, IDX_CT2: begin
                        rdata_r <= ct_rdata_i; // RQ22
                    end
                    IDX_DIOLO: begin
                        rdata_r <= dio_i[7:0]; // RQ20
                    end
                    IDX_DIOHI: begin
                        rdata_r <= dio_i[15:8]; // RQ20
                    end
                    IDX_BOARD_IDENTIFICATION: begin
                        rdata_r <= BOARD_IDENTIFICATION_VAL; // RQ3
                    end
                    default: begin
                        rdata_r <= 8'h00; // RQ26
                    end
                endcase
            end else if (acc(PORT_LSB, IDX_ADC)) begin
                rdata_r <= {4'h0, adc_r[3:0]}; // RQ13
            end else if (acc(PORT_MSB, IDX_ADC)) begin
                rdata_r <= adc_r[11:4]; // RQ13
            end
        end
    end

    // Counter core glue
    assign ct_sel_o = bus.index[1:0] == 2'h3 ? 2'h3 : bus.index[1:0] - 2'h0;
    assign ct_wr_o = bus.wr && bus.port == PORT_CTRL
        && (bus.index == IDX_CT0 || bus.index == IDX_CT1
        || bus.index == IDX_CT2 || bus.index == IDX_CTCTL);
    assign ct_rd_o = bus.rd && bus.port == PORT_CTRL
        && (bus.index == IDX_CT0 || bus.index == IDX_CT1
        || bus.index == IDX_CT2);
    assign ct_wdata_o = bus.wdata;
    assign ct0_clk_sel_o = counter0_clock_strap_i; // RQ24

    assign rdata_o = rdata_r;
    assign adc_start_o = adc_start_r;
    assign mux_sel_o = mux_r;
    assign analog_out_a_o = dac_a_r;
    assign analog_out_b_o = dac_b_r;
    assign user_ind_o = user_ind_r;
endmodule // idq_daq_ctrl

// ===== bench/idq_daq_monitor.sv
// Checker: port-level assertions for the indexed control block
// Assumes binding to idq_daq_ctrl, one clock, async high reset
`timescale 1ns/100ps
module idq_daq_monitor
    import idq_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o,
    input wire logic [2:0] adc_trigger_straps_i,
    input wire logic adc_start_o,
    input wire logic adc_done_i,
    input wire logic [3:0] mux_sel_o,
    input wire logic [11:0] analog_out_a_o,
    input wire logic [15:0] dio_i,
    input wire logic counter1_output_i,
    input wire logic user_ind_o,
    input wire logic ct_wr_o,
    input wire logic ct_rd_o,
    input wire logic [1:0] ct_sel_o,
    input wire logic [7:0] ct_wdata_o
);
    logic [7:0] idx_r;
    logic ctl_wr;
    logic ctl_rd;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Mirror of the index register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_r <= INDEX_RST;
        end else if (wr_i && addr_i == PORT_INDEX) begin
            idx_r <= wdata_i;
        end
    end
    assign ctl_wr = wr_i && addr_i == PORT_CTRL;
    assign ctl_rd = rd_i && addr_i == PORT_CTRL;
    AST_SW_START:
    assert property (ctl_wr && idx_r == IDX_ADC && adc_trigger_straps_i[0]
        |=> adc_start_o) else $error("software start missing");
    AST_IRQ_ADC:
    assert property (adc_done_i |=> irq_o) else $error("adc irq missing");
    AST_IRQ_CT:
    assert property ($rose(counter1_output_i) |-> ##[1:3] irq_o)
        else $error("counter irq missing");
    AST_IRQ_HOLD:
    assert property (irq_o && !wr_i && !rd_i |=> irq_o)
        else $error("irq dropped without access");
    AST_BOARD_IDENTIFICATION:
    assert property (ctl_rd && idx_r == IDX_BOARD_IDENTIFICATION |=>
        rdata_o == BOARD_IDENTIFICATION_VAL) else $error("board_identification wrong");
    AST_USER_IND:
    assert property (ctl_wr && idx_r == IDX_USER_IND |=>
        user_ind_o == $past(wdata_i[0])) else $error("indicator wrong");
    AST_MUX:
    assert property (ctl_wr && idx_r == IDX_MUX |=>
        mux_sel_o == $past(wdata_i[3:0])) else $error("mux wrong");
    AST_DIO_RD:
    assert property (ctl_rd && idx_r == IDX_DIOLO |=>
        rdata_o == $past(dio_i[7:0])) else $error("line read wrong");
    AST_DAC_A:
    assert property (wr_i && addr_i == PORT_MSB && idx_r == IDX_ANALOG_OUT_A |=>
        analog_out_a_o[11:4] == $past(wdata_i)) else $error("dac wrong");
    AST_UNUSED:
    assert property (ctl_rd && idx_r >= 8'h0c && idx_r <= 8'h7f |=>
        rdata_o == 8'h00) else $error("unused index not zero");
    AST_CT_WR:
    assert property (ctl_wr && idx_r >= IDX_CT0 && idx_r <= IDX_CTCTL |->
        ct_wr_o && ct_sel_o == idx_r[1:0] && ct_wdata_o == wdata_i)
        else $error("counter write not passed");
    AST_CT_RD:
    assert property (ctl_rd && idx_r >= IDX_CT0 && idx_r <= IDX_CT2 |->
        ct_rd_o && ct_sel_o == idx_r[1:0]) else $error("counter read missing");
endmodule // idq_daq_monitor

bind idq_daq_ctrl idq_daq_monitor i_idq_daq_monitor (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .adc_trigger_straps_i(adc_trigger_straps_i), .adc_start_o(adc_start_o),
    .adc_done_i(adc_done_i), .mux_sel_o(mux_sel_o),
    .analog_out_a_o(analog_out_a_o), .dio_i(dio_i),
    .counter1_output_i(counter1_output_i), .user_ind_o(user_ind_o),
    .ct_wr_o(ct_wr_o), .ct_rd_o(ct_rd_o), .ct_sel_o(ct_sel_o),
    .ct_wdata_o(ct_wdata_o)
);

// ===== bench/idq_adc_model.sv
// Partner: converter answering each start pulse with one result unless a new start restarts it
// Assumes a one-cycle start pulse on ref_clk_i
`timescale 1ns/100ps
module idq_adc_model #(
    parameter int CONV_CYC = 6
) (
    input wire logic ref_clk_i,
    input wire logic start_i,
    input wire logic [11:0] value_i,
    output logic done_o,
    output logic [11:0] data_o
);
    int cnt = 0;
    initial done_o = 1'b0;
    initial data_o = 12'h000;
    always @(posedge ref_clk_i) begin
        done_o <= 1'b0;
        // Result lines toggle outside the done cycle
        data_o <= ~data_o;
        if (start_i) begin
            cnt <= CONV_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                done_o <= 1'b1;
                data_o <= value_i;
            end
        end
    end
endmodule // idq_adc_model

// ===== bench/indexed_daq_io_control_tb.sv
// Testbench: scenario tasks over the four-port indexed bus
// Assumes idq_daq_ctrl with its bound checker and converter model
`timescale 1ns/100ps
module indexed_daq_io_control_tb;
    import idq_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, irq, adc_start, adc_done;
    logic [1:0] addr = 0, ct_sel;
    logic [7:0] wdata = 0, rdata, ct_wdata, d, ct_rdata = 8'h3c;
    logic [2:0] straps = 3'h1;
    logic [3:0] mux, dstr = 4'h5;
    logic ext_n = 1, c0 = 1, c1 = 0, ct_wr, ct_rd, csel, ind, cks = 1;
    logic [11:0] adc_data, adc_val = 12'ha5c, dac_a, dac_b;
    logic [15:0] dio_i, dio_o, dio_oe, ext = 16'h6b2d;
    int num_errors = 0, cmp_count = 0, n_start = 0, n0, cyc = 0;
    assign dio_i = (dio_oe & dio_o) | (~dio_oe & ext);
    always #5 clk = ~clk;
    always @(negedge clk) if (adc_start === 1'b1) n_start++;
    idq_daq_ctrl #(.MIN_TRIG_CYC(3)) i_idq_daq_ctrl (
        .ref_clk_i(clk), .rst_i(rst), .wr_i(wr), .rd_i(rd), .addr_i(addr),
        .wdata_i(wdata), .rdata_o(rdata), .irq_o(irq),
        .adc_trigger_straps_i(straps), .dio_reset_straps_i(dstr),
        .counter0_clock_strap_i(cks), .adc_start_o(adc_start),
        .adc_done_i(adc_done), .adc_data_i(adc_data), .mux_sel_o(mux),
        .ext_convert_n_i(ext_n), .analog_out_a_o(dac_a),
        .analog_out_b_o(dac_b), .dio_i(dio_i), .dio_o(dio_o),
        .dio_oe_o(dio_oe), .ct_wr_o(ct_wr), .ct_rd_o(ct_rd),
        .ct_sel_o(ct_sel), .ct_wdata_o(ct_wdata), .ct_rdata_i(ct_rdata),
        .ct0_clk_sel_o(csel), .counter0_output_i(c0),
        .counter1_output_i(c1), .user_ind_o(ind));
    idq_adc_model i_idq_adc_model (.ref_clk_i(clk), .start_i(adc_start),
        .value_i(adc_val), .done_o(adc_done), .data_o(adc_data));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bw(input logic [1:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic br(input logic [1:0] a);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        d = rdata;
    endtask
    task automatic rg(input logic [7:0] i, input logic [7:0] v);
        bw(PORT_INDEX, i);
        bw(PORT_CTRL, v);
    endtask
    task automatic t_reset;
        chk(dio_o, 16'h0f0f);
        chk(dio_oe, 16'hffff);
        chk({csel, irq}, 2'h2);
    endtask
    task automatic t_special;
        logic [7:0] unused_idx [4] = '{8'h0c, 8'h7f, 8'h82, 8'hff};
        rg(IDX_USER_IND, 8'h01);
        chk(ind, 1'b1);
        rg(IDX_USER_IND, 8'hfe);
        chk(ind, 1'b0);
        rg(IDX_BOARD_IDENTIFICATION, 8'h00);
        br(PORT_CTRL);
        chk(d, BOARD_IDENTIFICATION_VAL);
        foreach (unused_idx[k]) begin
            rg(unused_idx[k], 8'hff);
            br(PORT_CTRL);
            chk(d, 8'h00);
        end
    endtask
    task automatic t_adc_sw;
        rg(IDX_MUX, 8'hf9);
        chk(mux, 4'h9);
        repeat (5000) @(negedge clk);
        rg(IDX_ADC, 8'h00);
        for (int i = 0; i < 50 && irq !== 1'b1; i++) @(negedge clk);
        chk(irq, 1'b1);
        br(PORT_CTRL);
        chk(d[0], 1'b0);
        br(PORT_LSB);
        chk({d[3:0], irq}, 5'h19);
        br(PORT_MSB);
        chk({d, irq}, 9'h14a);
        br(PORT_CTRL);
        chk(d[0], 1'b1);
        // New start before the old result is read: old data still there
        adc_val = 12'h3e1;
        rg(IDX_ADC, 8'h00);
        br(PORT_LSB);
        chk(d[3:0], 4'hc);
        br(PORT_MSB);
        chk(d, 8'ha5);
        for (int i = 0; i < 50 && irq !== 1'b1; i++) @(negedge clk);
        br(PORT_MSB);
        chk({d, irq}, 9'h07c);
    endtask
    task automatic t_trig(input logic [2:0] s, input int exp);
        straps = s;
        n0 = n_start;
        rg(IDX_ADC, 8'h00);
        ext_n = 0;
        repeat (150) @(negedge clk);
        ext_n = 1;
        repeat (20) @(negedge clk);
        c0 = 0;
        repeat (100) @(negedge clk);
        c0 = 1;
        repeat (20) @(negedge clk);
        chk(n_start - n0, exp);
        br(PORT_MSB);
        chk(irq, 1'b0);
    endtask
    task automatic t_ct;
        c1 = 1;
        repeat (4) @(negedge clk);
        chk(irq, 1'b1);
        br(PORT_CTRL);
        chk(d[1], 1'b0);
        rg(IDX_MUX, 8'h00);
        chk(irq, 1'b1);
        rg(IDX_CTCLR, 8'h00);
        chk(irq, 1'b0);
        bw(PORT_INDEX, IDX_ADC);
        br(PORT_CTRL);
        chk(d[1], 1'b1);
        c1 = 0;
    endtask
    task automatic t_dac_dio;
        bw(PORT_INDEX, IDX_ANALOG_OUT_A);
        bw(PORT_LSB, 8'ha7);
        bw(PORT_MSB, 8'h5c);
        bw(PORT_INDEX, IDX_ANALOG_OUT_B);
        bw(PORT_LSB, 8'h30);
        bw(PORT_MSB, 8'hc1);
        chk({dac_a, dac_b[3:0]}, 16'h5ca3);
        chk(dac_b, 12'hc13);
        rg(IDX_DIOCFG, 8'h0a);
        chk(dio_oe, 16'h0f0f);
        rg(IDX_DIOLO, 8'h3c);
        br(PORT_CTRL);
        chk(d, 8'h2c);
        rg(IDX_DIOHI, 8'h00);
        rg(IDX_DIOCFG, 8'h0e);
        bw(PORT_INDEX, IDX_DIOHI);
        br(PORT_CTRL);
        chk(d, 8'h6b);
        rg(IDX_CT0, 8'h64);
        bw(PORT_INDEX, IDX_CT1);
        br(PORT_CTRL);
        chk(d, 8'h3c);
    endtask
    task automatic t_rerst;
        dstr = 4'ha;
        cks = 0;
        @(negedge clk);
        rst = 1;
        @(negedge clk);
        chk(dio_o, 16'hf0f0);
        chk(csel, 1'b0);
        chk(dio_oe, 16'hffff);
        @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        chk(dio_o, 16'hf0f0);
        br(PORT_CTRL);
        chk(d, 8'h03);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            $display("ERROR %0t: run did not complete", $time);
            finish_test;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        t_reset;
        t_special;
        t_adc_sw;
        t_trig(3'h1, 1);
        t_trig(3'h2, 1);
        t_trig(3'h4, 1);
        t_trig(3'h0, 0);
        t_ct;
        t_dac_dio;
        t_rerst;
        finish_test;
    end
endmodule // indexed_daq_io_control_tb
